// ### hw/isr_status.sv
// module: top of the status reporting and service request block
//
// Contract
// - status byte bit 5 is true when any enabled recorded standard event is true.
// - status byte bit 4 is one while the output queue holds data.
// - status byte bits 0, 3 and 7 always read zero.
// - status byte bits 1 and 2 summarise the two extended event registers.
// - serial poll returns the status byte with RQS in bit 6, byte unchanged.
// - RQS clears right after a poll; a repeat poll reads it false.
// - MSS is the OR of status bits ANDed with enable bits, bit 6 ignored.
// - clear status clears event registers and summaries, queue kept unless flagged.
// - clear status after a terminator or before queries also empties the queue.
// - clear status leaves every enable register unchanged.
// - an enabled set status bit raises a service request with RQS one.
// - enable query returns the enable byte with bit 6 reading zero.
// - enable writes take the byte as given and ignore bit 6.
// - writing zero to the enable register stops all service requests.
// - power-up clears the service request enable register.
// - standard event bit 7 is set when power is applied.
// - standard event bits 6 and 1 are unused and read zero.
// - command errors set standard event bit 5.
// - execution errors set standard event bit 4.
// - other device errors set standard event bit 3.
// - reading an empty queue or losing response data sets event bit 2.
// - event bit 0 is set only after the completion command once idle.
// - the event summary is the OR of event bits ANDed with enables.
// - event register query returns its value then clears it.
// - the 256-byte queue on overflow clears, resets responses, flags query error.
module isr_status #(
	parameter int OQ_DEPTH = isr_pkg::OQ_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	// serial poll
	input wire logic pollStrobe,
	output logic [7:0] pollByte,
	output logic pollValid,
	// common queries
	input wire logic stbQuery,
	output logic [7:0] stbQueryData,
	output logic stbQueryValid,
	input wire logic sreQuery,
	output logic [7:0] sreQueryData,
	output logic sreQueryValid,
	input wire logic esrQuery,
	output logic [7:0] esrQueryData,
	output logic esrQueryValid,
	// common commands
	input wire logic sreWrite,
	input wire logic [7:0] sreWriteData,
	input wire logic eseWrite,
	input wire logic [7:0] eseWriteData,
	input wire logic clsCmd,
	input wire logic clsFlushQueue,
	input wire logic opcCmd,
	input wire logic opBusy,
	// error events from the parser and executor
	input wire logic cmdError,
	input wire logic execError,
	input wire logic devError,
	input wire logic queryLost,
	// extended register summaries
	input wire logic ext1Summary,
	input wire logic ext2Summary,
	output logic extClear,
	// response data path
	input wire logic respPush,
	input wire logic [7:0] respPushData,
	input wire logic respPop,
	output logic [7:0] respPopData,
	output logic respPopValid,
	output logic respGenReset,
	// status outputs
	output logic [7:0] statusByte,
	output logic srqOut
);
	isr_link_if #(.DATA_W(isr_pkg::OQ_DATA_W)) lnk ();

	logic [7:0] stb_reg;
	logic [7:0] stb_next;
	logic [7:0] sre_reg;
	logic mss_reg;
	logic mssPrev_reg;
	logic rqs_reg;
	logic ponPending_reg;
	isr_pkg::isr_opc_e opcState_reg;
	isr_pkg::isr_opc_e opcState_next;
	logic opcDone;
	logic [7:0] eventSet;
	logic newCause;

	// output queue, flushed by the qualified clear status
	isr_out_queue #(
		.DEPTH(OQ_DEPTH),
		.DATA_W(isr_pkg::OQ_DATA_W)
	) u_queue (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.lnk(lnk)
	);

	// standard event register and its enable
	isr_event_reg u_events (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.lnk(lnk)
	);

	// queue control
	assign lnk.pushValid = respPush;
	assign lnk.pushData = respPushData;
	assign lnk.popReq = respPop;
	assign lnk.flush = clsCmd && clsFlushQueue;

	// event register control
	assign lnk.eventClear = clsCmd || esrQuery;
	assign lnk.eseWrite = eseWrite;
	assign lnk.eseData = eseWriteData;

	// collect standard events; bits 6 and 1 are never driven
	always_comb
	begin
		eventSet = 8'h00;
		eventSet[isr_pkg::EV_PON_BIT] = ponPending_reg;
		eventSet[isr_pkg::EV_CME_BIT] = cmdError;
		eventSet[isr_pkg::EV_EXE_BIT] = execError;
		eventSet[isr_pkg::EV_DDE_BIT] = devError;
		eventSet[isr_pkg::EV_QYE_BIT] = lnk.underflow || lnk.overflow || queryLost;
		eventSet[isr_pkg::EV_OPC_BIT] = opcDone;
	end
	assign lnk.eventSet = eventSet;

	// power-on event recorded in the first cycle after reset release
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			ponPending_reg <= 1'b1;
		else
			ponPending_reg <= 1'b0;
	end

	// operation complete tracker: armed by the command, fires once idle
	always_comb
	begin
		opcState_next = opcState_reg;
		opcDone = 1'b0;
		case (opcState_reg)
			isr_pkg::OPC_IDLE:
			begin
				if (opcCmd)
					opcState_next = isr_pkg::OPC_WAIT;
			end
			isr_pkg::OPC_WAIT:
			begin
				if (!opBusy)
				begin
					opcDone = 1'b1;
					opcState_next = opcCmd ? isr_pkg::OPC_WAIT : isr_pkg::OPC_IDLE;
				end
			end
			default:
			begin
				opcState_next = isr_pkg::OPC_IDLE;
			end
		endcase
	end

	// operation complete state register
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			opcState_reg <= isr_pkg::OPC_IDLE;
		else
			opcState_reg <= opcState_next;
	end

	// status byte assembly; unused bits and bit 6 stay zero
	always_comb
	begin
		stb_next = 8'h00;
		stb_next[isr_pkg::STB_EXT1_BIT] = ext1Summary;
		stb_next[isr_pkg::STB_EXT2_BIT] = ext2Summary;
		stb_next[isr_pkg::STB_MAV_BIT] = !lnk.empty;
		stb_next[isr_pkg::STB_ESB_BIT] = lnk.esb;
		if (clsCmd)
		begin
			stb_next[isr_pkg::STB_EXT1_BIT] = 1'b0;
			stb_next[isr_pkg::STB_EXT2_BIT] = 1'b0;
			stb_next[isr_pkg::STB_ESB_BIT] = 1'b0;
		end
		if (clsCmd && clsFlushQueue)
			stb_next[isr_pkg::STB_MAV_BIT] = 1'b0;
		stb_next = stb_next & isr_pkg::STB_USED_MASK;
	end

	// status byte register, refreshed every cycle; a poll never changes it
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			stb_reg <= isr_pkg::STB_RESET;
		else
			stb_reg <= stb_next;
	end

	// service request enable register
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			sre_reg <= isr_pkg::SRE_RESET;
		else if (sreWrite)
			sre_reg <= sreWriteData & isr_pkg::ENABLE_MASK;
	end

	// master summary from the unregistered next status byte and enables
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			mss_reg <= 1'b0;
			mssPrev_reg <= 1'b0;
		end
		else
		begin
			mss_reg <= isr_pkg::anyEnabled(stb_next, sre_reg);
			mssPrev_reg <= mss_reg;
		end
	end

	// a new cause is the master summary turning true
	assign newCause = mss_reg && !mssPrev_reg;

	// request service flag: set by a new cause, cleared by poll, clear status or a false master summary
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			rqs_reg <= 1'b0;
		else if (newCause)
			rqs_reg <= 1'b1;
		else if (pollStrobe || clsCmd || !mss_reg)
			rqs_reg <= 1'b0;
	end
	assign srqOut = rqs_reg;

	// serial poll answer: status byte with the request flag in bit 6
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pollByte <= 8'h00;
			pollValid <= 1'b0;
		end
		else
		begin
			pollValid <= pollStrobe;
			if (pollStrobe)
			begin
				pollByte <= stb_reg;
				pollByte[isr_pkg::STB_RQS_BIT] <= rqs_reg;
			end
		end
	end

	// status byte query answer with master summary in bit 6
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			stbQueryData <= 8'h00;
			stbQueryValid <= 1'b0;
		end
		else
		begin
			stbQueryValid <= stbQuery;
			if (stbQuery)
			begin
				stbQueryData <= stb_reg;
				stbQueryData[isr_pkg::STB_RQS_BIT] <= mss_reg;
			end
		end
	end

	// enable register query answer, bit 6 always zero
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			sreQueryData <= 8'h00;
			sreQueryValid <= 1'b0;
		end
		else
		begin
			sreQueryValid <= sreQuery;
			if (sreQuery)
				sreQueryData <= sre_reg & isr_pkg::ENABLE_MASK;
		end
	end

	// destructive event register query answer
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			esrQueryData <= 8'h00;
			esrQueryValid <= 1'b0;
		end
		else
		begin
			esrQueryValid <= esrQuery;
			if (esrQuery)
				esrQueryData <= lnk.esrValue;
		end
	end

	// clear pulse for the extended registers and response generator reset
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			extClear <= 1'b0;
			respGenReset <= 1'b0;
		end
		else
		begin
			extClear <= clsCmd;
			respGenReset <= lnk.overflow;
		end
	end

	// response data and visible status byte
	assign respPopData = lnk.popData;
	assign respPopValid = lnk.popValid;
	assign statusByte = stb_reg;
endmodule // isr_status

// ### hw/isr_pkg.sv
// package: status byte, event register and queue constants for the status reporting block
package isr_pkg;

	// status byte bit positions
	localparam int STB_EXT1_BIT = 1;
	localparam int STB_EXT2_BIT = 2;
	localparam int STB_MAV_BIT = 4;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_RQS_BIT = 6;
	localparam int STB_W = 8;

	// standard event bit positions
	localparam int EV_OPC_BIT = 0;
	localparam int EV_RQC_BIT = 1;
	localparam int EV_QYE_BIT = 2;
	localparam int EV_DDE_BIT = 3;
	localparam int EV_EXE_BIT = 4;
	localparam int EV_CME_BIT = 5;
	localparam int EV_URQ_BIT = 6;
	localparam int EV_PON_BIT = 7;

	// masks: bit 6 never enables, unused bits never set
	localparam logic [7:0] ENABLE_MASK = 8'hBF;
	localparam logic [7:0] STB_USED_MASK = 8'h36;
	localparam logic [7:0] EVENT_USED_MASK = 8'hBD;

	// reset values
	localparam logic [7:0] STB_RESET = 8'h00;
	localparam logic [7:0] SRE_RESET = 8'h00;
	localparam logic [7:0] ESR_RESET = 8'h00;
	localparam logic [7:0] ESE_RESET = 8'h00;

	// output queue geometry
	localparam int OQ_DEPTH = 256;
	localparam int OQ_DATA_W = 8;

	// operation complete tracker
	typedef enum logic [1:0] {
		OPC_IDLE = 2'b00,
		OPC_WAIT = 2'b01
	} isr_opc_e;

	// summary of status bits gated by enable bits, bit 6 forced to zero
	function automatic logic anyEnabled(input logic [7:0] status, input logic [7:0] enable);
		anyEnabled = |(status & enable & ENABLE_MASK);
	endfunction

endpackage

// ### hw/isr_link_if.sv
// interface: links the top of the status block to its queue and event register
interface isr_link_if #(parameter int DATA_W = 8);
	logic pushValid;
	logic [DATA_W-1:0] pushData;
	logic popReq;
	logic flush;
	logic [DATA_W-1:0] popData;
	logic popValid;
	logic empty;
	logic overflow;
	logic underflow;
	logic [7:0] eventSet;
	logic eventClear;
	logic eseWrite;
	logic [7:0] eseData;
	logic [7:0] esrValue;
	logic esb;

	modport queue (input pushValid, pushData, popReq, flush,
		output popData, popValid, empty, overflow, underflow);
	modport events (input eventSet, eventClear, eseWrite, eseData, output esrValue, esb);
	modport ctrl (output pushValid, pushData, popReq, flush, eventSet, eventClear, eseWrite, eseData,
		input popData, popValid, empty, overflow, underflow, esrValue, esb);
endinterface

// ### hw/isr_out_queue.sv
// module: response output queue in flip-flops with flush, overflow and underflow
module isr_out_queue #(
	parameter int DEPTH = isr_pkg::OQ_DEPTH,
	parameter int DATA_W = isr_pkg::OQ_DATA_W
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	isr_link_if.queue lnk
);
	localparam int AW = $clog2(DEPTH);

	logic [DATA_W-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW:0] count_reg;
	logic full;
	logic doPush;
	logic doPop;

	// occupancy decode
	assign full = (count_reg == (AW+1)'(DEPTH));
	assign doPush = lnk.pushValid && !full;
	assign doPop = lnk.popReq && (count_reg != '0);

	// storage
	always_ff @(posedge ref_clk)
	begin
		if (doPush)
			mem[wrPtr_reg] <= lnk.pushData;
	end

	// pointers and count; overflow empties the whole queue
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || lnk.flush || (lnk.pushValid && full))
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (doPush)
				wrPtr_reg <= wrPtr_reg + 1'b1;
			if (doPop)
				rdPtr_reg <= rdPtr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(doPush) - (AW+1)'(doPop);
		end
	end

	// read data, empty flag and error pulses
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			lnk.popData <= '0;
			lnk.popValid <= 1'b0;
			lnk.overflow <= 1'b0;
			lnk.underflow <= 1'b0;
		end
		else
		begin
			lnk.popValid <= doPop && !lnk.flush;
			lnk.popData <= doPop ? mem[rdPtr_reg] : lnk.popData;
			lnk.overflow <= lnk.pushValid && full && !lnk.flush;
			lnk.underflow <= lnk.popReq && (count_reg == '0);
		end
	end
	assign lnk.empty = (count_reg == '0);
endmodule // isr_out_queue

// ### hw/isr_event_reg.sv
// module: standard event register with its enable register and summary bit
module isr_event_reg (
	input wire logic ref_clk,
	input wire logic rst_n,
	isr_link_if.events lnk
);
	logic [7:0] esr_reg;
	logic [7:0] ese_reg;
	logic [7:0] esrClr;

	// sticky event bits; a set in the clearing cycle survives
	assign esrClr = lnk.eventClear ? 8'h00 : esr_reg;
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			esr_reg <= isr_pkg::ESR_RESET;
		else
			esr_reg <= esrClr | (lnk.eventSet & isr_pkg::EVENT_USED_MASK);
	end

	// enable register, untouched by clear status
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			ese_reg <= isr_pkg::ESE_RESET;
		else if (lnk.eseWrite)
			ese_reg <= lnk.eseData;
	end

	// event summary straight from the stored bits, so a clear leaves no stale summary behind
	assign lnk.esb = isr_pkg::anyEnabled(esr_reg, ese_reg);
	assign lnk.esrValue = esr_reg;
endmodule // isr_event_reg

// ### tb/isr_status_sva.sv
// checker: port-level timing of the status reporting block
module isr_status_sva (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic pollStrobe,
	input wire logic [7:0] pollByte,
	input wire logic pollValid,
	input wire logic stbQuery,
	input wire logic [7:0] stbQueryData,
	input wire logic stbQueryValid,
	input wire logic [7:0] sreQueryData,
	input wire logic sreQueryValid,
	input wire logic [7:0] esrQueryData,
	input wire logic esrQueryValid,
	input wire logic clsCmd,
	input wire logic extClear,
	input wire logic ext1Summary,
	input wire logic ext2Summary,
	input wire logic respGenReset,
	input wire logic [7:0] statusByte,
	input wire logic srqOut
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// poll answers one cycle later with the byte and the request bit
	poll_valid_a: assert property (pollStrobe |=> pollValid) else $error("poll not answered");
	poll_byte_a: assert property (pollStrobe |=> pollByte == {$past(statusByte[7]), $past(srqOut),
		$past(statusByte[5:0])}) else $error("poll byte wrong");
	// status query carries the status bits, bit 7 unused
	stb_query_a: assert property (stbQuery |=> stbQueryValid && !stbQueryData[7] &&
		stbQueryData[5:0] == $past(statusByte[5:0])) else $error("status query wrong");
	// unused status bits stay low
	stb_unused_a: assert property (!statusByte[7] && !statusByte[3] && !statusByte[0])
		else $error("unused status bit set");
	// extended summaries follow their inputs one cycle later
	ext_summary_a: assert property ($past(rst_n) && !$past(clsCmd) |->
		statusByte[2:1] == $past({ext2Summary, ext1Summary})) else $error("extended summary stale");
	sre_bit6_a: assert property (sreQueryValid |-> !sreQueryData[6]) else $error("enable bit 6 set");
	esr_unused_a: assert property (esrQueryValid |-> !esrQueryData[6] && !esrQueryData[1])
		else $error("unused event bit set");
	// clear status pulses the extended clear and drops the request
	cls_ext_a: assert property (clsCmd |=> extClear) else $error("no extended clear");
	cls_srq_a: assert property (clsCmd |=> !srqOut) else $error("request kept after clear");
	cls_sum_a: assert property (clsCmd |=> !statusByte[5] && !statusByte[2] && !statusByte[1])
		else $error("summary kept after clear");

	// main scenarios
	poll_c: cover property (pollValid && pollByte[6]);
	esr_c: cover property (esrQueryValid && esrQueryData[7]);
	ovf_c: cover property (respGenReset);
endmodule // isr_status_sva

bind isr_status isr_status_sva u_sva (.ref_clk, .rst_n, .pollStrobe, .pollByte, .pollValid, .stbQuery,
	.stbQueryData, .stbQueryValid, .sreQueryData, .sreQueryValid, .esrQueryData, .esrQueryValid, .clsCmd,
	.extClear, .ext1Summary, .ext2Summary, .respGenReset, .statusByte, .srqOut);

// ### tb/isr_ctl_model.sv
// model: bus controller issuing polls, common queries and enable writes
module isr_ctl_model (
	input wire logic clk,
	output logic [3:0] qry,
	input wire logic [3:0] vld,
	input wire logic [31:0] ans,
	output logic [2:0] wr,
	output logic [7:0] wd,
	output logic fl
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle bus at time zero
	initial
	begin
		qry = '0;
		wr = '0;
		wd = '0;
		fl = 1'b0;
	end

	// one request pulse, then wait for its answer under a bound
	task automatic query(input int k, output logic [7:0] d);
		int n;
		@(posedge clk) qry[k] <= 1'b1;
		@(posedge clk) qry[k] <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (vld[k] !== 1'b1 && n < 8);
		d = ans[k*8 +: 8];
	endtask

	// command with a whole weighted byte, bit 6 as the caller gives it
	task automatic put(input int k, input logic [7:0] v);
		@(posedge clk)
		begin
			wr[k] <= 1'b1;
			wd <= v;
			fl <= v[0];
		end
		@(posedge clk) wr[k] <= 1'b0;
	endtask
endmodule // isr_ctl_model

// ### tb/testbench.sv
// testbench: status reporting block against a behavioural status model
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DEPTH = 4;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [6:0] ev = '0;
	logic opBusy = 1'b0;
	logic [1:0] ext = '0;
	logic [7:0] pd = '0;
	wire [3:0] qry;
	wire [3:0] vld;
	wire [2:0] wr;
	wire [31:0] ans;
	wire [7:0] wd;
	wire fl;
	logic [7:0] statusByte, rd, d, v;
	logic srqOut, rv, rg;
	int miscompares = 0;
	int n_tests = 0;
	int gen = 0;
	int esr = 0;
	int ese = 0;
	int k;
	int q[$];

	always #12.5 ref_clk = ~ref_clk;

	isr_ctl_model C (.clk(ref_clk), .qry(qry), .vld(vld), .ans(ans), .wr(wr), .wd(wd), .fl(fl));
	isr_status #(.OQ_DEPTH(DEPTH)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .pollStrobe(qry[0]),
		.pollByte(ans[7:0]), .pollValid(vld[0]), .stbQuery(qry[1]), .stbQueryData(ans[15:8]),
		.stbQueryValid(vld[1]), .sreQuery(qry[2]), .sreQueryData(ans[23:16]), .sreQueryValid(vld[2]),
		.esrQuery(qry[3]), .esrQueryData(ans[31:24]), .esrQueryValid(vld[3]), .sreWrite(wr[0]),
		.sreWriteData(wd), .eseWrite(wr[1]), .eseWriteData(wd), .clsCmd(wr[2]), .clsFlushQueue(fl),
		.opcCmd(ev[6]), .opBusy(opBusy), .cmdError(ev[0]), .execError(ev[1]), .devError(ev[2]),
		.queryLost(ev[3]), .ext1Summary(ext[0]), .ext2Summary(ext[1]), .extClear(), .respPush(ev[4]),
		.respPushData(pd), .respPop(ev[5]), .respPopData(rd), .respPopValid(rv), .respGenReset(rg),
		.statusByte(statusByte), .srqOut(srqOut));

	// count response generator resets
	always @(posedge ref_clk)
		if (rg === 1'b1) gen++;

	// expected status byte from the model state
	function automatic int sb();
		return (int'((esr & ese) != 0) << 5) | (int'(q.size() != 0) << 4) | (int'(ext) << 1);
	endfunction

	task automatic chk(input logic [7:0] g, input int e);
		n_tests++;
		if (g !== e[7:0])
		begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, g, e[7:0]);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic pulse(input int i);
		@(posedge ref_clk) ev[i] <= 1'b1;
		@(posedge ref_clk) ev[i] <= 1'b0;
	endtask

	task automatic push();
		v = 8'($urandom);
		pd <= v;
		q.push_back(v);
		pulse(4);
	endtask

	// destructive event read against the model
	task automatic esr_chk();
		C.query(3, d);
		chk(d, esr);
		esr = 0;
	endtask

	task automatic conclude();
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// watchdog against a hang
	initial
	begin
		wt(20000);
		miscompares++;
		conclude();
	end

	// main sequence
	initial
	begin
		void'($urandom(7080));
		wt(20);
		rst_n <= 1'b1;
		wt(3);
		esr = 8'h80;
		esr_chk();
		esr_chk();
		C.query(2, d);
		chk(d, 0);
		repeat (4)
		begin
			v = 8'($urandom);
			C.put(0, v);
			C.query(2, d);
			chk(d, v & 8'hBF);
		end
		C.put(0, 8'h00);
		C.put(1, 8'hFF);
		ese = 8'hFF;
		for (k = 0; k < 4; k++)
		begin
			pulse(k);
			esr = 8'h20 >> k;
			wt(4);
			chk(statusByte, sb());
			chk(srqOut, 0);
			esr_chk();
		end
		repeat (4)
		begin
			ext <= 2'($urandom);
			wt(3);
			chk(statusByte, sb());
		end
		ext <= 2'b00;
		repeat (2) push();
		C.put(0, 8'h10);
		wt(4);
		chk(statusByte, sb());
		chk(srqOut, 1);
		C.query(1, d);
		chk(d, sb() | 8'h40);
		C.query(0, d);
		chk(d, sb() | 8'h40);
		C.query(0, d);
		chk(d, sb());
		repeat (2)
		begin
			pulse(5);
			@(posedge ref_clk);
			chk(rv, 1);
			chk(rd, q.pop_front());
		end
		pulse(5);
		esr = 8'h04;
		wt(5);
		chk(statusByte, sb());
		esr_chk();
		push();
		pulse(0);
		wt(2);
		C.put(2, 8'h00);
		esr = 0;
		wt(4);
		chk(statusByte, sb());
		chk(srqOut, 0);
		esr_chk();
		C.query(2, d);
		chk(d, 8'h10);
		C.put(2, 8'h01);
		q.delete();
		wt(4);
		chk(statusByte, sb());
		repeat (DEPTH + 1) push();
		q.delete();
		esr = 8'h04;
		wt(5);
		chk(gen, 1);
		chk(statusByte, sb());
		esr_chk();
		opBusy <= 1'b1;
		pulse(6);
		wt(4);
		esr_chk();
		opBusy <= 1'b0;
		esr = 8'h01;
		wt(4);
		esr_chk();
		conclude();
	end
endmodule // testbench
